// ---- rtl/pcr_processor_control.sv ----
// Summary of operation
// RULE1: carry flag set on carry or borrow
// RULE2: zero flag set on zero result
// RULE3: writable window base, bits 15 to 4
// RULE4: register address is base OR index shifted
// RULE5: window base resets to 0x0100
// RULE6: software writes zeros to reserved bits
// RULE7: read-only silicon revision register
// RULE8: divider slows only the processor
// RULE9: processor rate is clock over divisor plus one
// RULE10: power register selects sleep or halt
// RULE11: other writable power bits enable wake sources
// RULE12: port 2B wake raises no processor interrupt
// RULE13: sleep stops clock, analog; resumes within limit
// RULE14: halt stops processor until enabled interrupt
// RULE15: booster status reads one when not good
// RULE16: reserved bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none

module pcr_processor_control
  import pcr_pkg::*;
#(
  parameter int RESUME_CYCLES = PCR_RESUME_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire pcr_bus_req_type bus_req,
  output logic [15:0] bus_rdata,
  // Processor flag updates
  input wire pcr_alu_flags_type alu_flags,
  // General register window
  input wire logic [3:0] gpr_index,
  output logic [15:0] gpr_ram_addr,
  // Pending enabled interrupt
  input wire logic irq_pending,
  // Asynchronous wake and status pins
  input wire logic [PCR_WAKE_PINS-1:0] wake_pins,
  input wire logic booster_good,
  // Clock enables and power controls
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic cpu_run,
  output logic internal_clk_stop,
  output logic analog_power_down
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int SYNC_W = PCR_WAKE_PINS + 1;
  localparam int CNT_W = $clog2(RESUME_CYCLES + 1);

  wire logic [SYNC_W-1:0] raw_pins;
  wire logic [SYNC_W-1:0] stable_q;
  wire logic [SYNC_W-1:0] stable_d;

  assign raw_pins = {booster_good, wake_pins};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      logic meta_q;
      logic mid_q;
      logic late_q;
      logic held_q;
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          meta_q <= 1'b0;
          mid_q <= 1'b0;
          late_q <= 1'b0;
          held_q <= 1'b0;
        end else begin
          meta_q <= raw_pins[gi];
          mid_q <= meta_q;
          late_q <= mid_q;
          held_q <= stable_d[gi];
        end
      end
      // New level accepted once stages two and three agree
      assign stable_d[gi] = (mid_q == late_q) ? late_q : held_q;
      assign stable_q[gi] = held_q;
    end
  endgenerate

  // Chain fills from reset zeros; no edges until it holds real pin levels
  logic [3:0] fill_q;
  wire logic pins_primed;
  assign pins_primed = fill_q[3];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fill_q <= 4'h0;
    end else begin
      fill_q <= {fill_q[2:0], 1'b1};
    end
  end

  wire logic [SYNC_W-1:0] pin_change;
  wire logic [SYNC_W-1:0] pin_fall;
  wire logic [SYNC_W-1:0] pin_rise;
  assign pin_change = pins_primed ? (stable_d ^ stable_q) : '0;
  assign pin_fall = pin_change & stable_q;
  assign pin_rise = pin_change & stable_d;

  // ****************************************
  // Register storage
  // ****************************************
  logic carry_q;
  logic zero_q;
  logic [15:0] window_base_q;
  logic [3:0] divider_q;
  logic [15:0] wake_enable_q;
  pcr_power_state_type state_q;
  pcr_power_state_type state_d;

  wire logic sel_flags;
  wire logic sel_base;
  wire logic sel_revision;
  wire logic sel_divider;
  wire logic sel_power;
  wire logic wr_base;
  wire logic wr_divider;
  wire logic wr_power;
  assign sel_flags = (bus_req.addr == PCR_ADDR_FLAGS);
  assign sel_base = (bus_req.addr == PCR_ADDR_WINDOW_BASE);
  assign sel_revision = (bus_req.addr == PCR_ADDR_REVISION);
  assign sel_divider = (bus_req.addr == PCR_ADDR_CLOCK_DIVIDER);
  assign sel_power = (bus_req.addr == PCR_ADDR_POWER_WAKE);
  // Flags and revision are read-only; writes there fall through
  assign wr_base = bus_req.wr && sel_base;
  assign wr_divider = bus_req.wr && sel_divider;
  assign wr_power = bus_req.wr && sel_power;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      carry_q <= 1'b0;
      zero_q <= 1'b0;
    end else if (alu_flags.flag_we) begin
      carry_q <= alu_flags.carry; // [RULE1]
      zero_q <= alu_flags.zero; // [RULE2]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      window_base_q <= PCR_WINDOW_BASE_RESET; // [RULE5]
    end else if (wr_base) begin
      window_base_q <= bus_req.wdata & PCR_WINDOW_BASE_MASK; // [RULE3] [RULE16]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divider_q <= PCR_DIVIDER_RESET; // [RULE9]
    end else if (wr_divider) begin
      divider_q <= bus_req.wdata[3:0]; // [RULE9] [RULE16]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_enable_q <= PCR_WAKE_ENABLE_RESET; // [RULE11]
    end else if (wr_power) begin
      wake_enable_q <= bus_req.wdata & PCR_WAKE_ENABLE_MASK; // [RULE11] [RULE16]
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  wire logic [15:0] flags_view;
  wire logic [15:0] power_view;
  logic [15:0] rdata_d;
  assign flags_view = {14'h0000, carry_q, zero_q}; // [RULE16]
  // Booster bit inverted: one means not good
  assign power_view = wake_enable_q
                    | {13'h0000, ~stable_q[SYNC_W-1], // [RULE15]
                       state_q == PCR_ST_SLEEP, state_q == PCR_ST_HALT};

  // Idle cycles and unmapped addresses return zero
  always_comb begin
    rdata_d = 16'h0000;
    if (!bus_req.rd) begin
      rdata_d = 16'h0000;
    end else if (sel_flags) begin
      rdata_d = flags_view;
    end else if (sel_base) begin
      rdata_d = window_base_q;
    end else if (sel_revision) begin
      rdata_d = PCR_SILICON_REVISION; // [RULE7]
    end else if (sel_divider) begin
      rdata_d = {12'h000, divider_q};
    end else if (sel_power) begin
      rdata_d = power_view;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_rdata <= 16'h0000;
    end else begin
      bus_rdata <= rdata_d;
    end
  end

  // ****************************************
  // General register window address
  // ****************************************
  // Base low nibble is always zero, but index bit 3 lands on base bit 4 and the two are ORed
  wire logic [15:0] gpr_addr_d;
  assign gpr_addr_d = (window_base_q | {11'h000, gpr_index, 1'b0}) & 16'hFFFE; // [RULE4]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gpr_ram_addr <= 16'h0000;
    end else begin
      gpr_ram_addr <= gpr_addr_d;
    end
  end

  // ****************************************
  // Wake sources
  // ****************************************
  // Port wakes only end sleep; no processor interrupt is produced here
  wire logic [3:0] usb_wake;
  wire logic otg_wake;
  wire logic fss_wake;
  wire logic spi_wake;
  wire logic host_wake;
  wire logic gpi_wake;
  wire logic wake_hit;

  assign usb_wake[0] = wake_enable_q[PCR_PWR_USB1A_WAKE_BIT] && pin_change[PCR_PIN_USB1A];
  assign usb_wake[1] = wake_enable_q[PCR_PWR_USB1B_WAKE_BIT] && pin_change[PCR_PIN_USB1B];
  assign usb_wake[2] = wake_enable_q[PCR_PWR_USB2A_WAKE_BIT] && pin_change[PCR_PIN_USB2A];
  assign usb_wake[3] = wake_enable_q[PCR_PWR_USB2B_WAKE_BIT] && pin_change[PCR_PIN_USB2B]; // [RULE12]
  assign otg_wake = wake_enable_q[PCR_PWR_OTG_WAKE_BIT]
                  && (pin_change[PCR_PIN_OTG_VBUS] || pin_change[PCR_PIN_OTG_ID]);
  assign fss_wake = wake_enable_q[PCR_PWR_FSS_WAKE_BIT] && pin_change[PCR_PIN_FSS_RX];
  assign spi_wake = wake_enable_q[PCR_PWR_SPI_WAKE_BIT] && pin_fall[PCR_PIN_SPI_SEL_N];
  assign host_wake = wake_enable_q[PCR_PWR_HOST_WAKE_BIT] && pin_rise[PCR_PIN_HOST_READ];
  assign gpi_wake = wake_enable_q[PCR_PWR_GPI_WAKE_BIT]
                  && (pin_change[PCR_PIN_GPI0] || pin_change[PCR_PIN_GPI1]);
  assign wake_hit = (|usb_wake) || otg_wake || fss_wake || spi_wake || host_wake
                  || gpi_wake; // [RULE11]

  // ****************************************
  // Power state machine
  // ****************************************
  logic [CNT_W-1:0] resume_cnt_q;
  logic [CNT_W-1:0] resume_cnt_d;

  // Sleep wins when both mode bits come in one write
  always_comb begin
    state_d = state_q;
    resume_cnt_d = resume_cnt_q;
    case (state_q)
      PCR_ST_RUN: begin
        if (wr_power && bus_req.wdata[PCR_PWR_SLEEP_BIT]) begin
          state_d = PCR_ST_SLEEP; // [RULE10] [RULE13]
        end else if (wr_power && bus_req.wdata[PCR_PWR_HALT_BIT]) begin
          state_d = PCR_ST_HALT; // [RULE10] [RULE14]
        end
      end
      PCR_ST_HALT: begin
        if (irq_pending) begin
          state_d = PCR_ST_RUN; // [RULE14]
        end
      end
      PCR_ST_SLEEP: begin
        if (wake_hit) begin
          state_d = PCR_ST_RESUME; // [RULE13]
          resume_cnt_d = CNT_W'(RESUME_CYCLES - 1);
        end
      end
      PCR_ST_RESUME: begin
        if (resume_cnt_q == '0) begin
          state_d = PCR_ST_RUN; // [RULE13]
        end else begin
          resume_cnt_d = resume_cnt_q - CNT_W'(1);
        end
      end
      default: begin
        state_d = PCR_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= PCR_ST_RUN;
      resume_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      resume_cnt_q <= resume_cnt_d;
    end
  end

  // ****************************************
  // Processor clock divider
  // ****************************************
  // Count restarts whenever the processor is stopped
  logic [3:0] div_cnt_q;
  wire logic div_wrap;
  wire logic cpu_enabled_d;
  assign cpu_enabled_d = (state_d == PCR_ST_RUN);
  assign div_wrap = (div_cnt_q >= divider_q);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_cnt_q <= 4'h0;
      cpu_clk_en <= 1'b0;
    end else if (!cpu_enabled_d) begin
      div_cnt_q <= 4'h0;
      cpu_clk_en <= 1'b0;
    end else begin
      div_cnt_q <= div_wrap ? 4'h0 : div_cnt_q + 4'h1; // [RULE9]
      cpu_clk_en <= div_wrap; // [RULE9]
    end
  end

  // ****************************************
  // Power outputs
  // ****************************************
  wire logic asleep_d;
  assign asleep_d = (state_d == PCR_ST_SLEEP);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      periph_clk_en <= 1'b0;
      cpu_run <= 1'b0;
      internal_clk_stop <= 1'b0;
      analog_power_down <= 1'b0;
    end else begin
      periph_clk_en <= !asleep_d; // [RULE8] [RULE13]
      cpu_run <= cpu_enabled_d; // [RULE14]
      internal_clk_stop <= asleep_d; // [RULE13]
      analog_power_down <= asleep_d; // [RULE13]
    end
  end

endmodule

`default_nettype wire

// ---- include/pcr_pkg.sv ----
package pcr_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] PCR_ADDR_FLAGS = 16'hC000;
  localparam logic [15:0] PCR_ADDR_WINDOW_BASE = 16'hC002;
  localparam logic [15:0] PCR_ADDR_REVISION = 16'hC004;
  localparam logic [15:0] PCR_ADDR_CLOCK_DIVIDER = 16'hC008;
  localparam logic [15:0] PCR_ADDR_POWER_WAKE = 16'hC00A;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int PCR_FLAG_ZERO_BIT = 0;
  localparam int PCR_FLAG_CARRY_BIT = 1;
  localparam logic [15:0] PCR_WINDOW_BASE_RESET = 16'h0100;
  localparam logic [15:0] PCR_WINDOW_BASE_MASK = 16'hFFF0;
  localparam logic [3:0] PCR_DIVIDER_RESET = 4'hF;
  localparam logic [15:0] PCR_DIVIDER_MASK = 16'h000F;
  localparam int PCR_PWR_HALT_BIT = 0;
  localparam int PCR_PWR_SLEEP_BIT = 1;
  localparam int PCR_PWR_BOOSTER_BIT = 2;
  localparam int PCR_PWR_GPI_WAKE_BIT = 4;
  localparam int PCR_PWR_HOST_WAKE_BIT = 7;
  localparam int PCR_PWR_SPI_WAKE_BIT = 8;
  localparam int PCR_PWR_FSS_WAKE_BIT = 9;
  localparam int PCR_PWR_OTG_WAKE_BIT = 11;
  localparam int PCR_PWR_USB1A_WAKE_BIT = 12;
  localparam int PCR_PWR_USB1B_WAKE_BIT = 13;
  localparam int PCR_PWR_USB2A_WAKE_BIT = 14;
  localparam int PCR_PWR_USB2B_WAKE_BIT = 15;
  localparam logic [15:0] PCR_WAKE_ENABLE_MASK = 16'hFB90;
  localparam logic [15:0] PCR_WAKE_ENABLE_RESET = 16'h0000;

  // Arbitrary neutral value, not a real part's code
  localparam logic [15:0] PCR_SILICON_REVISION = 16'h0A5C;

  // ****************************************
  // Wake pin positions
  // ****************************************
  localparam int PCR_WAKE_PINS = 11;
  localparam int PCR_PIN_USB1A = 0;
  localparam int PCR_PIN_USB1B = 1;
  localparam int PCR_PIN_USB2A = 2;
  localparam int PCR_PIN_USB2B = 3;
  localparam int PCR_PIN_OTG_VBUS = 4;
  localparam int PCR_PIN_OTG_ID = 5;
  localparam int PCR_PIN_FSS_RX = 6;
  localparam int PCR_PIN_SPI_SEL_N = 7;
  localparam int PCR_PIN_HOST_READ = 8;
  localparam int PCR_PIN_GPI0 = 9;
  localparam int PCR_PIN_GPI1 = 10;

  // ****************************************
  // Timing
  // ****************************************
  localparam int PCR_CLK_PERIOD_PS = 8000;
  localparam int PCR_RESUME_TIME_US = 500;
  localparam int PCR_RESUME_CYCLES = (PCR_RESUME_TIME_US * 1000000) / PCR_CLK_PERIOD_PS;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pcr_bus_req_type;

  typedef struct packed {
    logic flag_we;
    logic carry;
    logic zero;
  } pcr_alu_flags_type;

  typedef enum logic [1:0] {
    PCR_ST_RUN = 2'b00,
    PCR_ST_HALT = 2'b01,
    PCR_ST_SLEEP = 2'b10,
    PCR_ST_RESUME = 2'b11
  } pcr_power_state_type;

endpackage

// ---- testbench/pcr_processor_control_chk.sv ----
`timescale 1ns/1ps
`default_nettype none

module pcr_processor_control_chk
  import pcr_pkg::*;
#(
  parameter int RESUME_CYCLES = PCR_RESUME_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire pcr_bus_req_type bus_req,
  input wire logic [15:0] bus_rdata,
  // Register window
  input wire logic [3:0] gpr_index,
  input wire logic [15:0] gpr_ram_addr,
  // Power outputs
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic cpu_run,
  input wire logic internal_clk_stop,
  input wire logic analog_power_down
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ****************************************
  // Divider gap tracking
  // ****************************************
  logic [3:0] div_q;
  logic [4:0] gap_q;
  logic gap_ok_q;
  wire logic div_wr = bus_req.wr && bus_req.addr == PCR_ADDR_CLOCK_DIVIDER;
  wire logic mapped = bus_req.addr inside {PCR_ADDR_FLAGS, PCR_ADDR_WINDOW_BASE,
    PCR_ADDR_REVISION, PCR_ADDR_CLOCK_DIVIDER, PCR_ADDR_POWER_WAKE};

  always_ff @(posedge clk) begin
    div_q <= !rst_n ? PCR_DIVIDER_RESET : (div_wr ? bus_req.wdata[3:0] : div_q);
    gap_q <= cpu_clk_en ? 5'h00 : gap_q + 5'h01;
    gap_ok_q <= (!rst_n || div_wr || !cpu_run) ? 1'b0 : (gap_ok_q || cpu_clk_en);
  end

  // ****************************************
  // Properties
  // ****************************************
  sequence s_rd(logic [15:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  sequence s_base_wr;
    bus_req.wr && bus_req.addr == PCR_ADDR_WINDOW_BASE;
  endsequence

  property p_rev;
    s_rd(PCR_ADDR_REVISION) |=> bus_rdata == PCR_SILICON_REVISION;
  endproperty
  property p_unmapped;
    bus_req.rd && !mapped |=> bus_rdata == 16'h0000;
  endproperty
  property p_div_rsvd;
    s_rd(PCR_ADDR_CLOCK_DIVIDER) |=> bus_rdata[15:4] == 12'h000;
  endproperty
  property p_pwr_rsvd;
    s_rd(PCR_ADDR_POWER_WAKE) |=> (bus_rdata & 16'h0468) == 16'h0000;
  endproperty
  property p_base_write;
    s_base_wr ##1 s_rd(PCR_ADDR_WINDOW_BASE)
      |=> bus_rdata == ($past(bus_req.wdata, 2) & PCR_WINDOW_BASE_MASK);
  endproperty
  property p_gpr;
    rst_n |=> gpr_ram_addr[3:0] == 4'($past(gpr_index) << 1);
  endproperty
  property p_sleep_enter;
    bus_req.wr && bus_req.addr == PCR_ADDR_POWER_WAKE && bus_req.wdata[1] && cpu_run
      |=> internal_clk_stop && analog_power_down;
  endproperty
  property p_sleep;
    internal_clk_stop |-> analog_power_down && !cpu_run && !cpu_clk_en && !periph_clk_en;
  endproperty
  property p_periph;
    $past(rst_n) && !internal_clk_stop |-> periph_clk_en;
  endproperty
  property p_clk_run;
    cpu_clk_en |-> cpu_run;
  endproperty
  property p_div_gap;
    cpu_clk_en && gap_ok_q |-> gap_q == {1'b0, div_q};
  endproperty

  a_rev: assert property (p_rev) else $error("revision read wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  a_div_rsvd: assert property (p_div_rsvd) else $error("divider reserved bits set");
  a_pwr_rsvd: assert property (p_pwr_rsvd) else $error("power reserved bits set");
  a_base_write: assert property (p_base_write) else $error("window base readback");
  a_gpr: assert property (p_gpr) else $error("register address low bits");
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");
  a_sleep: assert property (p_sleep) else $error("sleep outputs wrong");
  a_periph: assert property (p_periph) else $error("peripheral clock stopped");
  a_clk_run: assert property (p_clk_run) else $error("processor enable while stopped");
  a_div_gap: assert property (p_div_gap) else $error("processor enable spacing");
endmodule

bind pcr_processor_control pcr_processor_control_chk #(.RESUME_CYCLES(RESUME_CYCLES)) i_chk (
  .clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .gpr_index(gpr_index), .gpr_ram_addr(gpr_ram_addr), .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en), .cpu_run(cpu_run), .internal_clk_stop(internal_clk_stop),
  .analog_power_down(analog_power_down)
);

`default_nettype wire

// ---- testbench/pcr_processor_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module pcr_processor_control_tb
  import pcr_pkg::*;
;
  logic clk, rst_n, irq_pending, booster_good;
  logic cpu_clk_en, periph_clk_en, cpu_run, internal_clk_stop, analog_power_down;
  logic [3:0] gpr_index;
  logic [15:0] bus_rdata, gpr_ram_addr, rd_v, v;
  logic [PCR_WAKE_PINS-1:0] wake_pins;
  pcr_bus_req_type bus_req;
  pcr_alu_flags_type alu_flags;
  int n_mismatch, cmp_count, seed, i, j, k;
  logic [15:0] ens[11] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800,
    16'h0200, 16'h0100, 16'h0080, 16'h0010, 16'h0800, 16'h0010};
  int pins[11] = '{PCR_PIN_USB2B, PCR_PIN_USB2A, PCR_PIN_USB1B, PCR_PIN_USB1A,
    PCR_PIN_OTG_VBUS, PCR_PIN_FSS_RX, PCR_PIN_SPI_SEL_N, PCR_PIN_HOST_READ, PCR_PIN_GPI0,
    PCR_PIN_OTG_ID, PCR_PIN_GPI1};

  pcr_processor_control #(.RESUME_CYCLES(8)) i_dut (
    .clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .alu_flags(alu_flags), .gpr_index(gpr_index), .gpr_ram_addr(gpr_ram_addr),
    .irq_pending(irq_pending), .wake_pins(wake_pins), .booster_good(booster_good),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .cpu_run(cpu_run),
    .internal_clk_stop(internal_clk_stop), .analog_power_down(analog_power_down)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] exp_addr(logic [15:0] base, logic [3:0] idx);
    return ((base & PCR_WINDOW_BASE_MASK) | {11'h000, idx, 1'b0}) & 16'hFFFE;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic outs(input logic [3:0] e, input string what);
    chk({12'h000, cpu_run, periph_clk_en, internal_clk_stop, analog_power_down},
      {12'h000, e}, what);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 rd_v = bus_rdata;
  endtask

  // Write then read with no idle cycle between
  task automatic wr_rd(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 rd_v = bus_rdata;
  endtask

  task automatic give_verdict;
    $display("Compared %0d, mismatched %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("Error watchdog expected finish seen timeout");
    give_verdict();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    seed = 81;
    rst_n = 1'b0;
    bus_req = '0;
    alu_flags = '0;
    gpr_index = 4'h0;
    irq_pending = 1'b0;
    booster_good = 1'b1;
    wake_pins = PCR_WAKE_PINS'(1 << PCR_PIN_SPI_SEL_N);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(PCR_ADDR_WINDOW_BASE); chk(rd_v, 16'h0100, "base reset");
    rd(PCR_ADDR_CLOCK_DIVIDER); chk(rd_v, 16'h000F, "divider reset");
    rd(PCR_ADDR_POWER_WAKE); chk(rd_v, 16'h0000, "power reset");
    rd(PCR_ADDR_REVISION); chk(rd_v, PCR_SILICON_REVISION, "revision");
    rd(16'hC006); chk(rd_v, 16'h0000, "unmapped");
    $display("reset test done");
    for (i = 0; i < 8; i++) begin
      v = (i == 0) ? 16'hFFFF : 16'($random(seed));
      wr_rd(PCR_ADDR_WINDOW_BASE, v & PCR_WINDOW_BASE_MASK);
      chk(rd_v, v & PCR_WINDOW_BASE_MASK, "base");
      @(posedge clk) gpr_index <= v[7:4];
      tick(1); chk(gpr_ram_addr, exp_addr(v, v[7:4]), "register address");
    end
    for (i = 0; i < 4; i++) begin
      @(posedge clk) alu_flags <= '{flag_we: 1'b1, carry: i[1], zero: i[0]};
      @(posedge clk) alu_flags.flag_we <= 1'b0;
      rd(PCR_ADDR_FLAGS); chk(rd_v, {14'h0000, i[1:0]}, "flags");
    end
    $display("window and flags test done");
    for (i = 0; i < 3; i++) begin
      v = (i == 0) ? 16'h0000 : (i == 1) ? 16'($random(seed)) : 16'hFFFF;
      wr(PCR_ADDR_CLOCK_DIVIDER, v & PCR_DIVIDER_MASK);
      rd(PCR_ADDR_CLOCK_DIVIDER); chk(rd_v, v & PCR_DIVIDER_MASK, "divider");
      for (j = 0; j < 2; j++) begin
        k = 0;
        do begin tick(1); k++; end while (cpu_clk_en !== 1'b1 && k < 40);
      end
      chk(16'(k), {12'h000, v[3:0]} + 16'h0001, "processor period");
    end
    $display("divider test done");
    wr(PCR_ADDR_POWER_WAKE, 16'h0001);
    tick(1); outs(4'b0100, "halt outputs");
    @(posedge clk) booster_good <= 1'b0;
    tick(6);
    rd(PCR_ADDR_POWER_WAKE); chk(rd_v, 16'h0005, "halt and booster status");
    @(posedge clk) booster_good <= 1'b1;
    @(posedge clk) irq_pending <= 1'b1;
    @(posedge clk) irq_pending <= 1'b0;
    tick(1); outs(4'b1100, "halt exit");
    $display("halt test done");
    tick(6);
    for (j = 0; j < 11; j++) begin
      wr(PCR_ADDR_POWER_WAKE, ens[j] | 16'h0002);
      tick(1); outs(4'b0011, "sleep outputs");
      rd(PCR_ADDR_POWER_WAKE); chk(rd_v, ens[j] | 16'h0002, "wake enables");
      if (j == 0) begin
        @(posedge clk) wake_pins[PCR_PIN_USB1A] <= ~wake_pins[PCR_PIN_USB1A];
        tick(16); outs(4'b0011, "disabled source");
      end
      @(posedge clk) wake_pins[pins[j]] <= ~wake_pins[pins[j]];
      k = 0;
      do begin tick(1); k++; end while (cpu_run !== 1'b1 && k < 60);
      outs(4'b1100, "woken");
    end
    $display("sleep test done");
    give_verdict();
  end
endmodule

`default_nettype wire
